/* File: logic/cp2_defines.svh */
// Shared constants for the second port pair and line RAM interface.
`ifndef CP2_DEFINES_SVH
`define CP2_DEFINES_SVH

`define CP2_TRANS_IDLE 2'h0
`define CP2_TRANS_BUSY 2'h1
`define CP2_TRANS_NSEQ 2'h2
`define CP2_TRANS_SEQ 2'h3
`define CP2_RESP_OKAY 3'h0
`define CP2_RESP_ERROR 3'h1
`define CP2_BURST_SINGLE 3'h0
`define CP2_SIZE_8 2'h0
`define CP2_SIZE_16 2'h1
`define CP2_SIZE_32 2'h2
`define CP2_SIZE_64 2'h3
`define CP2_DFLT_ID 4'hf
`define CP2_DFLT_PROT 6'h0f
`define CP2_DFLT_SIDEBAND 4'he
`define CP2_IDX_LSB 5
`define CP2_DW_LSB 3
`define CP2_RST_RDATA 64'h0

`endif

/* File: logic/cp2_pkg.sv */
// Types shared by the port pair, its property checker and the bench.
package cp2_pkg;

	typedef enum logic [2:0] {
		CP2_S_IDLE = 3'h0,
		CP2_S_ISSUE = 3'h1,
		CP2_S_WAIT = 3'h3,
		CP2_S_ERR1 = 3'h2,
		CP2_S_ERR2 = 3'h6
	} cp2_sstate_t;

	typedef enum logic [1:0] {
		CP2_M_IDLE = 2'h0,
		CP2_M_ADDR = 2'h1,
		CP2_M_DATA = 2'h3
	} cp2_mstate_t;

	typedef enum logic [1:0] {
		CP2_K_NCNB = 2'h0,
		CP2_K_LINEFILL = 2'h1,
		CP2_K_BUFWRITE = 2'h2,
		CP2_K_EVICT = 2'h3
	} cp2_kind_t;

endpackage : cp2_pkg

/* File: logic/cp2_line_ram.sv */
// Line RAM and parity RAM access driver with per-byte parity check.
`timescale 1ns/100ps
`include "cp2_defines.svh"

module cp2_line_ram #(
	parameter int IDX_W = 16,
	parameter int WORD_W = 256,
	parameter int NBYTE = 32
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic acc_req,
	input wire logic acc_write,
	input wire logic [IDX_W-1:0] acc_index,
	input wire logic [WORD_W-1:0] acc_wword,
	input wire logic [NBYTE-1:0] acc_ben,
	output logic acc_done,
	output logic [WORD_W-1:0] acc_rword,
	output logic acc_error,
	output logic line_ram_select,
	output logic [IDX_W-1:0] line_ram_index,
	output logic [NBYTE-1:0] line_ram_byte_enables,
	output logic line_ram_write_not_read,
	output logic [WORD_W-1:0] line_ram_write_word,
	input wire logic [WORD_W-1:0] line_ram_read_word,
	input wire logic line_ram_error_in,
	output logic [NBYTE-1:0] parity_ram_byte_enables,
	output logic parity_ram_write_not_read,
	output logic [NBYTE-1:0] parity_write_word,
	input wire logic [NBYTE-1:0] line_parity_read_word
);

	logic [NBYTE-1:0] nxt_parity;
	logic [NBYTE-1:0] rd_parity;
	logic rd_pend_ff;
	logic wr_pend_ff;

	// One parity bit per byte, both for the outgoing word and the returned word.
	for (genvar b = 0; b < NBYTE; b++) begin : g_par
		assign nxt_parity[b] = ^acc_wword[b*8 +: 8];
		assign rd_parity[b] = ^line_ram_read_word[b*8 +: 8];
	end

	// Every access is one cycle of select with the index; enables only on writes.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			line_ram_select <= 1'b0;
			line_ram_index <= '0;
			line_ram_byte_enables <= '0;
			line_ram_write_not_read <= 1'b0;
			line_ram_write_word <= '0;
			parity_ram_byte_enables <= '0;
			parity_ram_write_not_read <= 1'b0;
			parity_write_word <= '0;
		end else begin
			line_ram_select <= acc_req;
			line_ram_index <= acc_req ? acc_index : line_ram_index;
			line_ram_byte_enables <= (acc_req && acc_write) ? acc_ben : '0;
			line_ram_write_not_read <= acc_req && acc_write;
			line_ram_write_word <= acc_req ? acc_wword : line_ram_write_word;
			parity_ram_byte_enables <= (acc_req && acc_write) ? acc_ben : '0;
			parity_ram_write_not_read <= acc_req && acc_write;
			parity_write_word <= acc_req ? nxt_parity : parity_write_word;
		end
	end

	// The RAM answers the cycle after its select, so the word is taken then.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_pend_ff <= 1'b0;
			wr_pend_ff <= 1'b0;
			acc_done <= 1'b0;
			acc_rword <= '0;
			acc_error <= 1'b0;
		end else begin
			rd_pend_ff <= line_ram_select && !line_ram_write_not_read;
			wr_pend_ff <= line_ram_select && line_ram_write_not_read;
			acc_done <= rd_pend_ff || wr_pend_ff;
			acc_rword <= rd_pend_ff ? line_ram_read_word : acc_rword;
			// A flagged or parity-broken word is reported rather than trusted.
			acc_error <= rd_pend_ff && (line_ram_error_in ||
				(rd_parity != line_parity_read_word));
		end
	end

endmodule : cp2_line_ram

/* File: logic/cp2_port_pair.sv */
// Second slave and master port pair driving the line RAM and register space.
`timescale 1ns/100ps
`include "cp2_defines.svh"

module cp2_port_pair #(
	parameter bit HAS_SLAVE2 = 1'b1,
	parameter bit HAS_MASTER2 = 1'b1,
	parameter int IDX_W = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic slave2_clock_enable,
	input wire logic slave2_select,
	input wire logic register_space_select,
	input wire logic [31:0] slave2_addr,
	input wire logic [7:0] slave2_byte_lane_strobes,
	input wire logic [2:0] slave2_burst,
	input wire logic [3:0] slave2_requester_id,
	input wire logic slave2_lock,
	input wire logic [5:0] slave2_prot,
	input wire logic [3:0] slave2_cache_attr_sideband,
	input wire logic [2:0] slave2_size,
	input wire logic [1:0] slave2_trans,
	input wire logic slave2_misaligned_flag,
	input wire logic slave2_write,
	input wire logic [63:0] slave2_wdata,
	output logic slave2_ready,
	output logic [2:0] slave2_resp,
	output logic [63:0] slave2_rdata,
	output logic reg_req,
	output logic reg_write,
	output logic [31:0] reg_addr,
	output logic [63:0] reg_wdata,
	output logic [3:0] reg_requester_id,
	output logic [5:0] reg_prot,
	input wire logic reg_ack,
	input wire logic reg_err,
	input wire logic [63:0] reg_rdata,
	input wire logic master2_clock_enable,
	input wire logic master2_ready_in,
	input wire logic [2:0] master2_resp_in,
	input wire logic [63:0] master2_rdata_in,
	output logic [31:0] master2_addr,
	output logic [7:0] master2_byte_lane_strobes,
	output logic [2:0] master2_burst,
	output logic master2_lock,
	output logic [3:0] master2_requester_id,
	output logic [5:0] master2_protection_attr,
	output logic [3:0] master2_cache_attr_sideband,
	output logic [2:0] master2_size,
	output logic [1:0] master2_trans,
	output logic master2_misaligned_flag,
	output logic master2_write,
	output logic [63:0] master2_wdata,
	input wire logic m2_cmd_valid,
	output logic m2_cmd_ready,
	input wire cp2_pkg::cp2_kind_t m2_cmd_kind,
	input wire logic [31:0] m2_cmd_addr,
	input wire logic m2_cmd_write,
	input wire logic [1:0] m2_cmd_size,
	input wire logic m2_cmd_lock,
	input wire logic [7:0] m2_cmd_strobes,
	input wire logic m2_cmd_misaligned,
	input wire logic [3:0] m2_cmd_id,
	input wire logic [5:0] m2_cmd_prot,
	input wire logic [3:0] m2_cmd_sideband,
	input wire logic [63:0] m2_cmd_wdata,
	output logic m2_done,
	output logic m2_error,
	output logic [63:0] m2_rdata,
	output logic line_ram_fault,
	output logic line_ram_select,
	output logic [IDX_W-1:0] line_ram_index,
	output logic [31:0] line_ram_byte_enables,
	output logic line_ram_write_not_read,
	output logic [255:0] line_ram_write_word,
	input wire logic [255:0] line_ram_read_word,
	input wire logic line_ram_error_in,
	output logic [31:0] parity_ram_byte_enables,
	output logic parity_ram_write_not_read,
	output logic [31:0] parity_write_word,
	input wire logic [31:0] line_parity_read_word
);

	cp2_pkg::cp2_sstate_t s_state_ff;
	cp2_pkg::cp2_mstate_t m_state_ff;
	logic s_start;
	logic [31:0] s_addr_ff;
	logic s_write_ff;
	logic s_regsel_ff;
	logic [7:0] s_mask_ff;
	logic [7:0] nxt_mask;
	logic [3:0] s_id_ff;
	logic [5:0] s_prot_ff;
	logic acc_req;
	logic acc_done;
	logic acc_error;
	logic [255:0] acc_rword;
	logic [1:0] s_dw;
	logic [31:0] acc_ben;
	logic m_is_evict;
	logic m_default_id;

	// Byte mask from size and low address; the top size bit plays no part.
	function automatic logic [7:0] size_mask(input logic [2:0] sz, input logic [2:0] a);
		logic [7:0] base;
		base = 8'h00;
		unique case (sz[1:0])
			`CP2_SIZE_8: base = 8'h01;
			`CP2_SIZE_16: base = 8'h03;
			`CP2_SIZE_32: base = 8'h0f;
			`CP2_SIZE_64: base = 8'hff;
		endcase
		size_mask = base << a;
	endfunction : size_mask

	// A new address phase is taken only on an enabled edge with the port present.
	assign s_start = HAS_SLAVE2 && slave2_clock_enable && slave2_ready &&
		(slave2_select || register_space_select) &&
		slave2_trans[1] &&
		(s_state_ff == cp2_pkg::CP2_S_IDLE);
	assign nxt_mask = size_mask(slave2_size, slave2_addr[2:0]) & slave2_byte_lane_strobes;

	// Address phase attributes are held for the whole data phase.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_addr_ff <= '0;
			s_write_ff <= 1'b0;
			s_regsel_ff <= 1'b0;
			s_mask_ff <= '0;
			s_id_ff <= '0;
			s_prot_ff <= '0;
		end else if (s_start) begin
			s_addr_ff <= slave2_addr;
			s_write_ff <= slave2_write;
			s_regsel_ff <= register_space_select;
			s_mask_ff <= nxt_mask;
			s_id_ff <= slave2_requester_id;
			s_prot_ff <= slave2_prot;
		end
	end

	// Slave data phase sequencing, including the two-cycle error answer.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_state_ff <= cp2_pkg::CP2_S_IDLE;
		end else begin
			unique case (s_state_ff)
				cp2_pkg::CP2_S_IDLE: begin
					if (s_start) begin
						s_state_ff <= cp2_pkg::CP2_S_ISSUE;
					end
				end
				cp2_pkg::CP2_S_ISSUE: begin
					s_state_ff <= cp2_pkg::CP2_S_WAIT;
				end
				cp2_pkg::CP2_S_WAIT: begin
					if (s_regsel_ff ? reg_ack : acc_done) begin
						if (s_regsel_ff ? reg_err : acc_error) begin
							s_state_ff <= cp2_pkg::CP2_S_ERR1;
						end else begin
							s_state_ff <= cp2_pkg::CP2_S_IDLE;
						end
					end
				end
				cp2_pkg::CP2_S_ERR1: begin
					if (slave2_clock_enable) begin
						s_state_ff <= cp2_pkg::CP2_S_ERR2;
					end
				end
				cp2_pkg::CP2_S_ERR2: begin
					if (slave2_clock_enable) begin
						s_state_ff <= cp2_pkg::CP2_S_IDLE;
					end
				end
				default: begin
					s_state_ff <= cp2_pkg::CP2_S_IDLE;
				end
			endcase
		end
	end

	// Ready is low through issue, wait and the first error cycle.
	always_comb begin
		slave2_ready = (s_state_ff == cp2_pkg::CP2_S_IDLE) ||
			(s_state_ff == cp2_pkg::CP2_S_ERR2);
		slave2_resp = ((s_state_ff == cp2_pkg::CP2_S_ERR1) ||
			(s_state_ff == cp2_pkg::CP2_S_ERR2)) ? `CP2_RESP_ERROR : `CP2_RESP_OKAY;
	end

	// Read data is latched when the answer arrives and held until the next read.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			slave2_rdata <= `CP2_RST_RDATA;
		end else if (s_state_ff == cp2_pkg::CP2_S_WAIT && !s_write_ff) begin
			if (s_regsel_ff && reg_ack) begin
				slave2_rdata <= reg_rdata;
			end else if (!s_regsel_ff && acc_done) begin
				slave2_rdata <= acc_rword[s_dw*64 +: 64];
			end
		end
	end

	// Register space requests carry the write data sampled in the data phase.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_req <= 1'b0;
			reg_write <= 1'b0;
			reg_addr <= '0;
			reg_wdata <= '0;
			reg_requester_id <= '0;
			reg_prot <= '0;
		end else begin
			reg_req <= (s_state_ff == cp2_pkg::CP2_S_ISSUE) && s_regsel_ff;
			if (s_state_ff == cp2_pkg::CP2_S_ISSUE && s_regsel_ff) begin
				reg_write <= s_write_ff;
				reg_addr <= s_addr_ff;
				reg_wdata <= slave2_wdata;
				reg_requester_id <= s_id_ff;
				reg_prot <= s_prot_ff;
			end
		end
	end

	// Memory path: one doubleword lane of the line, placed by address bits.
	assign s_dw = s_addr_ff[`CP2_DW_LSB +: 2];
	assign acc_req = (s_state_ff == cp2_pkg::CP2_S_ISSUE) && !s_regsel_ff;
	assign acc_ben = {24'h0, s_mask_ff} << {s_dw, 3'h0};

	cp2_line_ram #(
		.IDX_W(IDX_W),
		.WORD_W(256),
		.NBYTE(32)
	) u_line_ram (
		.clk(clk),
		.rst_n(rst_n),
		.acc_req(acc_req),
		.acc_write(s_write_ff),
		.acc_index(s_addr_ff[`CP2_IDX_LSB +: IDX_W]),
		.acc_wword({4{slave2_wdata}}),
		.acc_ben(acc_ben),
		.acc_done(acc_done),
		.acc_rword(acc_rword),
		.acc_error(acc_error),
		.line_ram_select(line_ram_select),
		.line_ram_index(line_ram_index),
		.line_ram_byte_enables(line_ram_byte_enables),
		.line_ram_write_not_read(line_ram_write_not_read),
		.line_ram_write_word(line_ram_write_word),
		.line_ram_read_word(line_ram_read_word),
		.line_ram_error_in(line_ram_error_in),
		.parity_ram_byte_enables(parity_ram_byte_enables),
		.parity_ram_write_not_read(parity_ram_write_not_read),
		.parity_write_word(parity_write_word),
		.line_parity_read_word(line_parity_read_word)
	);

	// Faults also show as a pulse so the core can count them.
	assign line_ram_fault = acc_done && acc_error;

	// Evictions and buffered writes hide the requester behind default values.
	assign m_is_evict = (m2_cmd_kind == cp2_pkg::CP2_K_EVICT);
	assign m_default_id = m_is_evict || (m2_cmd_kind == cp2_pkg::CP2_K_BUFWRITE);
	assign m2_cmd_ready = HAS_MASTER2 && (m_state_ff == cp2_pkg::CP2_M_IDLE);

	// Master address phase; only single beats are issued, so burst stays single.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			master2_addr <= '0;
			master2_byte_lane_strobes <= '0;
			master2_burst <= `CP2_BURST_SINGLE;
			master2_lock <= 1'b0;
			master2_requester_id <= `CP2_DFLT_ID;
			master2_protection_attr <= `CP2_DFLT_PROT;
			master2_cache_attr_sideband <= `CP2_DFLT_SIDEBAND;
			master2_size <= 3'h0;
			master2_misaligned_flag <= 1'b0;
			master2_write <= 1'b0;
			master2_wdata <= '0;
		end else if (m2_cmd_valid && m2_cmd_ready) begin
			master2_addr <= m2_cmd_addr;
			master2_byte_lane_strobes <= m2_cmd_strobes;
			master2_burst <= `CP2_BURST_SINGLE;
			master2_lock <= m2_cmd_lock;
			master2_requester_id <= m_default_id ? `CP2_DFLT_ID : m2_cmd_id;
			master2_protection_attr <= m_is_evict ? `CP2_DFLT_PROT : m2_cmd_prot;
			master2_cache_attr_sideband <= m_is_evict ? `CP2_DFLT_SIDEBAND :
				m2_cmd_sideband;
			master2_size <= {1'b0, m2_cmd_size};
			master2_misaligned_flag <= m2_cmd_misaligned;
			master2_write <= m2_cmd_write;
			master2_wdata <= m2_cmd_wdata;
		end
	end

	// Master sequencing leaves the address and data phases only on enabled edges with the slave ready.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			m_state_ff <= cp2_pkg::CP2_M_IDLE;
			master2_trans <= `CP2_TRANS_IDLE;
		end else begin
			unique case (m_state_ff)
				cp2_pkg::CP2_M_IDLE: begin
					if (m2_cmd_valid && m2_cmd_ready) begin
						m_state_ff <= cp2_pkg::CP2_M_ADDR;
						master2_trans <= `CP2_TRANS_NSEQ;
					end
				end
				cp2_pkg::CP2_M_ADDR: begin
					if (master2_clock_enable && master2_ready_in) begin
						m_state_ff <= cp2_pkg::CP2_M_DATA;
						master2_trans <= `CP2_TRANS_IDLE;
					end
				end
				cp2_pkg::CP2_M_DATA: begin
					if (master2_clock_enable && master2_ready_in) begin
						m_state_ff <= cp2_pkg::CP2_M_IDLE;
					end
				end
				default: begin
					m_state_ff <= cp2_pkg::CP2_M_IDLE;
					master2_trans <= `CP2_TRANS_IDLE;
				end
			endcase
		end
	end

	// Completion is reported once, with the response and any read data.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			m2_done <= 1'b0;
			m2_error <= 1'b0;
			m2_rdata <= `CP2_RST_RDATA;
		end else begin
			m2_done <= (m_state_ff == cp2_pkg::CP2_M_DATA) &&
				master2_clock_enable && master2_ready_in;
			if (m_state_ff == cp2_pkg::CP2_M_DATA && master2_clock_enable &&
				master2_ready_in) begin
				m2_error <= (master2_resp_in != `CP2_RESP_OKAY);
				m2_rdata <= master2_write ? m2_rdata : master2_rdata_in;
			end
		end
	end

endmodule : cp2_port_pair

/* File: sim/cp2_port_properties.sv */
// Concurrent checks on the slave, master and line RAM ports of the port pair.
`timescale 1ns/100ps

module cp2_port_checker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic slave2_clock_enable,
	input wire logic slave2_select,
	input wire logic register_space_select,
	input wire logic [1:0] slave2_trans,
	input wire logic slave2_ready,
	input wire logic [2:0] slave2_resp,
	input wire logic reg_req,
	input wire logic master2_clock_enable,
	input wire logic master2_ready_in,
	input wire logic [1:0] master2_trans,
	input wire logic [3:0] master2_requester_id,
	input wire logic [5:0] master2_protection_attr,
	input wire logic [3:0] master2_cache_attr_sideband,
	input wire logic [2:0] master2_size,
	input wire logic m2_cmd_valid,
	input wire logic m2_cmd_ready,
	input wire cp2_pkg::cp2_kind_t m2_cmd_kind,
	input wire logic [3:0] m2_cmd_id,
	input wire logic [5:0] m2_cmd_prot,
	input wire logic [1:0] m2_cmd_size,
	input wire logic line_ram_select,
	input wire logic line_ram_write_not_read,
	input wire logic [31:0] line_ram_byte_enables,
	input wire logic parity_ram_write_not_read,
	input wire logic line_ram_fault
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic s_idle_req;
	logic m_take;

	// A request waiting at an idle slave.
	assign s_idle_req = slave2_ready && slave2_resp == 3'h0 && slave2_trans[1]
		&& (slave2_select || register_space_select);
	assign m_take = m2_cmd_valid && m2_cmd_ready;

	s_busy_a: assert property (s_idle_req && slave2_clock_enable |=> !slave2_ready)
		else $error("ready high after take");
	ce_gate_a: assert property (s_idle_req && !slave2_clock_enable |=> slave2_ready)
		else $error("advanced while disabled");
	mem_path_a: assert property (s_idle_req && slave2_clock_enable && !register_space_select
		|-> ##[2:6] line_ram_select) else $error("no line RAM select");
	reg_path_a: assert property (s_idle_req && slave2_clock_enable && register_space_select
		|-> ##[1:4] reg_req) else $error("no reg_req");
	sel_pulse_a: assert property (line_ram_select |=> !line_ram_select)
		else $error("select too long");
	read_en_a: assert property (line_ram_select && !line_ram_write_not_read
		|-> line_ram_byte_enables == 32'h0) else $error("enables on read");
	par_dir_a: assert property (line_ram_select
		|-> parity_ram_write_not_read == line_ram_write_not_read) else $error("parity direction");
	fault_resp_a: assert property (line_ram_fault |-> ##[0:2] slave2_resp == 3'h1)
		else $error("fault not answered");
	id_dflt_a: assert property (m_take && m2_cmd_kind inside {cp2_pkg::CP2_K_BUFWRITE,
		cp2_pkg::CP2_K_EVICT} |=> master2_requester_id == 4'hf) else $error("default id");
	id_fwd_a: assert property (m_take && m2_cmd_kind inside {cp2_pkg::CP2_K_NCNB,
		cp2_pkg::CP2_K_LINEFILL} |=> master2_requester_id == $past(m2_cmd_id)) else $error("id");
	evict_attr_a: assert property (m_take && m2_cmd_kind == cp2_pkg::CP2_K_EVICT
		|=> master2_protection_attr == 6'h0f && master2_cache_attr_sideband == 4'he)
		else $error("evict defaults");
	attr_fwd_a: assert property (m_take && m2_cmd_kind != cp2_pkg::CP2_K_EVICT
		|=> master2_protection_attr == $past(m2_cmd_prot)
		&& master2_size == {1'b0, $past(m2_cmd_size)}) else $error("forwarded attributes");
	nseq_hold_a: assert property (master2_trans == 2'h2
		&& !(master2_clock_enable && master2_ready_in) |=> master2_trans == 2'h2)
		else $error("address phase left early");
endmodule : cp2_port_checker

bind cp2_port_pair cp2_port_checker u_chk (.*);

/* File: sim/cp2_far_side.sv */
// Far-side model: downstream memory slave on the master port and the line RAMs.
`timescale 1ns/100ps

module cp2_far_side (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic err_mode,
	input wire logic line_ram_select,
	input wire logic [15:0] line_ram_index,
	output logic master2_clock_enable,
	output logic master2_ready_in,
	output logic [2:0] master2_resp_in,
	output logic [63:0] master2_rdata_in,
	output logic [255:0] line_ram_read_word,
	output logic [31:0] line_parity_read_word,
	output logic line_ram_error_in
);
	logic ce_ff;
	logic rdy_ff;
	logic vld_ff;
	logic [15:0] idx_ff;
	logic [255:0] word;
	logic [31:0] par;

	// A slow partner halves the port rate and stalls every other enabled edge.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ce_ff <= 1'b1;
			rdy_ff <= 1'b1;
		end else begin
			ce_ff <= slow ? !ce_ff : 1'b1;
			if (ce_ff)
				rdy_ff <= slow ? !rdy_ff : 1'b1;
		end
	end

	// The RAM answers one cycle after its select; otherwise it shows junk.
	always_ff @(posedge clk) begin
		vld_ff <= line_ram_select;
		if (line_ram_select)
			idx_ff <= line_ram_index;
	end

	// Each 64-bit lane differs so a wrong lane pick cannot pass.
	assign word = {{4{idx_ff ^ 16'h3}}, {4{idx_ff ^ 16'h2}}, {4{idx_ff ^ 16'h1}}, {4{idx_ff}}};
	assign line_ram_read_word = vld_ff ? word : ~word;
	// Even parity per byte, so a clean read must not be flagged.
	for (genvar b = 0; b < 32; b++) begin : g_par
		assign par[b] = ^word[8*b +: 8];
	end
	assign line_parity_read_word = vld_ff ? par : ~par;
	assign line_ram_error_in = vld_ff ? err_mode : !err_mode;
	assign master2_clock_enable = ce_ff;
	assign master2_ready_in = rdy_ff;
	assign master2_resp_in = 3'h0;
	assign master2_rdata_in = rdy_ff ? 64'h5a5a_5a5a_5a5a_5a5a : 64'ha5a5_a5a5_a5a5_a5a5;
endmodule : cp2_far_side

/* File: sim/tb_top.sv */
// Self-checking bench for the second port pair and line RAM interface.
`timescale 1ns/100ps

module tb_top;
	logic clk, rst_n, slave2_clock_enable, slave2_select, register_space_select, slave2_lock;
	logic slave2_misaligned_flag, slave2_write, slave2_ready, reg_req, reg_write, reg_ack, reg_err;
	logic master2_clock_enable, master2_ready_in, master2_lock, master2_misaligned_flag;
	logic master2_write, m2_cmd_valid, m2_cmd_ready, m2_cmd_write, m2_cmd_lock, m2_cmd_misaligned;
	logic m2_done, m2_error, line_ram_fault, line_ram_select, line_ram_write_not_read;
	logic line_ram_error_in, parity_ram_write_not_read, slow, err_mode, cap_nrw, cap_pnrw, fault_seen;
	logic [1:0] slave2_trans, master2_trans, m2_cmd_size;
	logic [2:0] slave2_burst, slave2_size, slave2_resp, master2_resp_in, master2_burst, master2_size;
	logic [3:0] slave2_requester_id, slave2_cache_attr_sideband, reg_requester_id;
	logic [3:0] master2_requester_id, master2_cache_attr_sideband, m2_cmd_id, m2_cmd_sideband;
	logic [5:0] slave2_prot, reg_prot, master2_protection_attr, m2_cmd_prot;
	logic [7:0] slave2_byte_lane_strobes, master2_byte_lane_strobes, m2_cmd_strobes;
	logic [15:0] line_ram_index, cap_idx;
	logic [31:0] slave2_addr, reg_addr, master2_addr, m2_cmd_addr, line_ram_byte_enables, cap_en;
	logic [31:0] parity_ram_byte_enables, parity_write_word, line_parity_read_word, cap_pen, cap_pwd;
	logic [63:0] slave2_wdata, slave2_rdata, reg_wdata, reg_rdata, master2_rdata_in;
	logic [63:0] master2_wdata, m2_cmd_wdata, m2_rdata;
	logic [255:0] line_ram_write_word, line_ram_read_word, cap_ww;
	cp2_pkg::cp2_kind_t m2_cmd_kind;
	int fail_count, num_checks, sel_cnt;

	cp2_port_pair dut (.*);
	cp2_far_side far (.*);

	always #4 clk = ~clk;

	// Record each line RAM access and answer register requests one cycle later.
	always @(posedge clk) begin
		if (line_ram_select) begin
			cap_en <= line_ram_byte_enables;
			cap_pen <= parity_ram_byte_enables;
			cap_nrw <= line_ram_write_not_read;
			cap_pnrw <= parity_ram_write_not_read;
			cap_pwd <= parity_write_word;
			cap_idx <= line_ram_index;
			cap_ww <= line_ram_write_word;
			sel_cnt <= sel_cnt + 1;
		end
		if (line_ram_fault)
			fault_seen <= 1'b1;
		reg_ack <= reg_req;
	end

	task automatic check(input string what, input logic [255:0] seen, input logic [255:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	function automatic logic [31:0] par(input logic [255:0] w);
		for (int b = 0; b < 32; b++)
			par[b] = ^w[8*b +: 8];
	endfunction : par

	// One slave transfer: address phase, then data phase until an enabled ready edge.
	task automatic s_xfer(input logic w, input logic rs, input logic [31:0] a,
		input logic [2:0] sz, input logic [63:0] d, output logic [2:0] rsp);
		int n;
		n = 0;
		rsp = 3'h0;
		slave2_select = !rs;
		register_space_select = rs;
		slave2_write = w;
		slave2_addr = a;
		slave2_size = sz;
		slave2_trans = 2'h2;
		do begin
			@(posedge clk);
			n++;
		end while (!(slave2_ready && slave2_clock_enable) && n < 60);
		#1;
		slave2_trans = 2'h0;
		slave2_select = 1'b0;
		register_space_select = 1'b0;
		slave2_wdata = d;
		do begin
			@(posedge clk);
			n++;
			if (slave2_resp !== 3'h0)
				rsp = slave2_resp;
		end while (!(slave2_ready && slave2_clock_enable) && n < 60);
		#1;
		check("slave handshake", n < 60, 1'b1);
	endtask : s_xfer

	// No take on disabled edges; then partial and full writes.
	task automatic t_writes();
		logic [31:0] a[3] = '{32'h68, 32'hb2, 32'h1f};
		logic [2:0] sz[3] = '{3'h3, 3'h5, 3'h4};
		logic [7:0] st[3] = '{8'hff, 8'hfb, 8'hff};
		logic [7:0] m;
		logic [63:0] d;
		logic [2:0] r;
		slave2_clock_enable = 1'b0;
		slave2_select = 1'b1;
		slave2_trans = 2'h2;
		repeat (5) @(posedge clk);
		#1;
		check("access while disabled", sel_cnt, 0);
		slave2_clock_enable = 1'b1;
		for (int i = 0; i < 3; i++) begin
			d = 64'h8877_6655_4433_2211 + i;
			slave2_byte_lane_strobes = st[i];
			s_xfer(1'b1, 1'b0, a[i], sz[i], d, r);
			m = 8'((16'h1 << (1 << sz[i][1:0])) - 16'h1);
			m = 8'(m << a[i][2:0]) & st[i];
			check("write enables", cap_en, 32'(m) << (8 * a[i][4:3]));
			check("parity enables", cap_pen, 32'(m) << (8 * a[i][4:3]));
			check("write direction", {cap_nrw, cap_pnrw}, 2'h3);
			check("line index", cap_idx, a[i][20:5]);
			check("write word", cap_ww, {4{d}});
			check("parity word", cap_pwd, par({4{d}}));
			check("write response", r, 3'h0);
		end
		$display("test writes done");
	endtask : t_writes

	// Reads pick the addressed lane; an erroring read is reported, not hidden.
	task automatic t_reads();
		logic [2:0] r;
		s_xfer(1'b0, 1'b0, 32'h68, 3'h3, 64'h0, r);
		check("read data", slave2_rdata, {4{16'h3 ^ 16'h1}});
		check("read direction", {cap_nrw, cap_en}, 33'h0);
		check("read response", r, 3'h0);
		err_mode = 1'b1;
		fault_seen = 1'b0;
		s_xfer(1'b0, 1'b0, 32'h1f0, 3'h3, 64'h0, r);
		err_mode = 1'b0;
		check("error response", r, 3'h1);
		check("fault flag", fault_seen, 1'b1);
		$display("test reads done");
	endtask : t_reads

	// Register select bypasses the line RAM and carries the attributes.
	task automatic t_regs();
		logic [2:0] r;
		int c;
		c = sel_cnt;
		s_xfer(1'b1, 1'b1, 32'h100, 3'h3, 64'hcafe, r);
		check("reg address", reg_addr, 32'h100);
		check("reg write", {reg_write, reg_wdata}, {1'b1, 64'hcafe});
		check("reg attributes", {reg_requester_id, reg_prot}, {4'h9, 6'h15});
		s_xfer(1'b0, 1'b1, 32'h104, 3'h2, 64'h0, r);
		check("reg read data", slave2_rdata, reg_rdata);
		check("line RAM untouched", sel_cnt, c);
		$display("test registers done");
	endtask : t_regs

	// Every command kind against a slow far side; defaults replace attributes.
	task automatic t_master();
		int n;
		slow = 1'b1;
		for (int k = 0; k < 4; k++) begin
			m2_cmd_kind = cp2_pkg::cp2_kind_t'(k);
			m2_cmd_write = k[1];
			m2_cmd_valid = 1'b1;
			n = 0;
			do begin
				@(posedge clk);
				n++;
			end while (!m2_cmd_ready && n < 60);
			#1;
			m2_cmd_valid = 1'b0;
			check("master trans", master2_trans, 2'h2);
			check("master id", master2_requester_id, k[1] ? 4'hf : 4'h3);
			check("master prot", master2_protection_attr, k == 3 ? 6'h0f : 6'h2a);
			check("master sideband", master2_cache_attr_sideband, k == 3 ? 4'he : 4'h5);
			check("master size", master2_size, 3'h1);
			check("master bus", {master2_addr, master2_byte_lane_strobes, master2_burst,
				master2_write}, {32'h40, 8'h0c, 3'h0, k[1]});
			do begin
				@(posedge clk);
				n++;
			end while (!m2_done && n < 120);
			#1;
			check("master done", {n < 120, m2_error}, 2'h2);
			if (k == 1)
				check("master read data", m2_rdata, 64'h5a5a_5a5a_5a5a_5a5a);
		end
		slow = 1'b0;
		$display("test master done");
	endtask : t_master

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test

	// Main sequence: reset for eight cycles, then each test in turn.
	initial begin
		{clk, rst_n, slave2_clock_enable, slave2_select, register_space_select} = '0;
		{slave2_lock, slave2_misaligned_flag, slave2_write, reg_err, m2_cmd_valid} = '0;
		{m2_cmd_write, m2_cmd_lock, m2_cmd_misaligned, slow, err_mode, fault_seen} = '0;
		{slave2_trans, slave2_burst, slave2_size, slave2_addr, slave2_wdata} = '0;
		{slave2_requester_id, slave2_prot, slave2_cache_attr_sideband} = {4'h9, 6'h15, 4'h6};
		{slave2_byte_lane_strobes, reg_rdata} = {8'hff, 64'h0123_4567_89ab_cdef};
		{m2_cmd_addr, m2_cmd_size, m2_cmd_strobes, m2_cmd_id} = {32'h40, 2'h1, 8'h0c, 4'h3};
		{m2_cmd_prot, m2_cmd_sideband, m2_cmd_wdata} = {6'h2a, 4'h5, 64'h1234};
		m2_cmd_kind = cp2_pkg::CP2_K_NCNB;
		repeat (8) @(posedge clk);
		#1;
		rst_n = 1'b1;
		check("reset id", master2_requester_id, 4'hf);
		t_writes();
		t_reads();
		t_regs();
		t_master();
		end_of_test();
	end

	// Watchdog, far beyond the expected run.
	initial begin
		#40000;
		fail_count++;
		$display("Error watchdog expected finish seen hang");
		end_of_test();
	end
endmodule : tb_top
